// [pkg/lrb_regs.vh]
// Register map, field positions and codes of the line region and binning path.
`ifndef LRB_REGS_VH
`define LRB_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define LRB_OFF_CTRL 8'h00
`define LRB_OFF_WIDTH 8'h04
`define LRB_OFF_OFFX 8'h08
`define LRB_OFF_OFFY 8'h0C
`define LRB_OFF_WMAX 8'h10
`define LRB_OFF_OXMAX 8'h14
`define LRB_OFF_STAT 8'h18
// ****************************************
// Control fields
// ****************************************
`define LRB_CTRL_LINE 0
`define LRB_CTRL_STAGES2 1
`define LRB_CTRL_BACK 2
`define LRB_CTRL_LOGIC 3
`define LRB_CTRL_HAVG 4
`define LRB_CTRL_HX2 5
`define LRB_CTRL_VAVG 6
`define LRB_CTRL_VX2 7
`define LRB_CTRL_FMT_LO 8
`define LRB_CTRL_FMT_HI 9
`define LRB_CTRL_MASK 32'h000003FF
`define LRB_CTRL_RESET 32'h00000001
// ****************************************
// Output sample layouts
// ****************************************
`define LRB_FMT_MONO 2'h0
`define LRB_FMT_RGB 2'h1
`define LRB_FMT_BGR 2'h2
`define LRB_FMT_RAW 2'h3
`endif

// [src/lrb_row_combine.v]
// Horizontal pair combiner for one or more pixel lanes.
`timescale 1ns/1ps
`default_nettype none
module lrb_row_combine #(
	parameter LANES = 2,
	parameter IW = 13
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Settings
	input wire factorTwo,
	input wire average,
	// Incoming pixels
	input wire inValid,
	input wire inStart,
	input wire [LANES*IW-1:0] inData,
	// Combined pixels
	output reg outValid,
	output reg outStart,
	output reg [LANES*(IW+1)-1:0] outData
);
	reg phase;
	reg startPend;
	reg [LANES*IW-1:0] held;
	reg [LANES*(IW+1)-1:0] next_pair;
	integer i;
	integer j;

	// ****************************************
	// Pair arithmetic
	// ****************************************
	always @* begin
		next_pair = {LANES*(IW+1){1'b0}};
		for (i = 0; i < LANES; i = i + 1) begin
			next_pair[i*(IW+1) +: IW+1] = {1'b0, held[i*IW +: IW]} + {1'b0, inData[i*IW +: IW]};
			if (average) begin
				next_pair[i*(IW+1) +: IW+1] = {1'b0, next_pair[i*(IW+1)+1 +: IW]};
			end
		end
	end

	// ****************************************
	// Pairing sequence
	// ****************************************
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 1'b0;
			startPend <= 1'b0;
			held <= {LANES*IW{1'b0}};
			outValid <= 1'b0;
			outStart <= 1'b0;
			outData <= {LANES*(IW+1){1'b0}};
		end else begin
			outValid <= 1'b0;
			outStart <= 1'b0;
			if (inValid) begin
				if (!factorTwo) begin
					outValid <= 1'b1;
					outStart <= inStart;
					for (j = 0; j < LANES; j = j + 1) begin
						outData[j*(IW+1) +: IW+1] <= {1'b0, inData[j*IW +: IW]};
					end
				end else if (!phase || inStart) begin
					held <= inData;
					phase <= 1'b1;
					startPend <= inStart;
				end else begin
					outValid <= 1'b1;
					outStart <= startPend;
					outData <= next_pair;
					phase <= 1'b0;
					startPend <= 1'b0;
				end
			end
		end
	end
endmodule // lrb_row_combine
`default_nettype wire

// [src/lrb_line_path.v]
// Line readout path with region crop, binning, colour layouts and a Wishbone register file.
`timescale 1ns/1ps
`default_nettype none
`include "lrb_regs.vh"
// Overview of operation
// - Scan layout bit selects line or area camera behaviour.
// - Line mode with two stages adds both sensor rows per position in mono layout.
// - Mono layout sends only the green photosite value.
// - RGB and BGR layouts fill missing colours from neighbouring sites.
// - Raw layout sends both photosite rows untouched, one pair per cycle.
// - Direction bit chooses forward or backward sensor readout.
// - Backward in area mode flags vertically flipped frames.
// - Only pixels from horizontal start over width are sent.
// - Vertical start reads zero while in line mode.
// - Width resets to maximum; software writes width before start.
// - Engine bit selects binning in sensor or in logic.
// - Horizontal sum adds each adjacent group into one pixel.
// - Horizontal average emits the mean of each group.
// - Horizontal factor is one or two.
// - Vertical factor one or two, by sum or average; binning in logic does this in mono layout only.
// - Two by two binning halves width and quadruples response.
// - Width, start and their maxima follow binning changes.
module lrb_line_path #(
	parameter PIX_W = 12,
	parameter SENSOR_W = 4096,
	parameter CNT_W = 13
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Sensor pixel stream
	input wire pixValid,
	input wire pixLineStart,
	input wire [PIX_W-1:0] pixTop,
	input wire [PIX_W-1:0] pixBottom,
	// Sensor controls
	output reg sensorStagesTwo,
	output reg sensorReadBackward,
	output reg sensorBinH,
	output reg sensorBinV,
	output reg frameFlipped,
	// Output stream to the frame grabber
	output reg outValid,
	output reg outLineStart,
	output reg [PIX_W+1:0] outComp0,
	output reg [PIX_W+1:0] outComp1,
	output reg [PIX_W+1:0] outComp2
);
	localparam IW = PIX_W + 1;
	localparam OW = PIX_W + 2;
	localparam [CNT_W-1:0] FULL_W = SENSOR_W[CNT_W-1:0];

	reg [31:0] ctrl;
	reg [CNT_W-1:0] roiWidth;
	reg [CNT_W-1:0] roiStart;
	reg [CNT_W-1:0] roiVertStart;
	reg [15:0] lineCount;
	reg [31:0] next_rd;
	reg [31:0] next_wr;
	reg [CNT_W-1:0] widthMax;
	reg prevHx2;
	wire lineMode;
	wire backward;
	wire logicEng;
	wire hx2;
	wire vx2;
	wire [1:0] layout;
	wire wbReq;

	assign lineMode = ctrl[`LRB_CTRL_LINE];
	assign backward = ctrl[`LRB_CTRL_BACK];
	assign logicEng = ctrl[`LRB_CTRL_LOGIC];
	assign hx2 = ctrl[`LRB_CTRL_HX2];
	assign vx2 = ctrl[`LRB_CTRL_VX2];
	assign layout = ctrl[`LRB_CTRL_FMT_HI:`LRB_CTRL_FMT_LO];
	assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// ****************************************
	// Helper functions
	// ****************************************
	function [31:0] merge;
		input [31:0] old;
		input [31:0] din;
		input [3:0] sel;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b]) begin
					merge[b*8 +: 8] = din[b*8 +: 8];
				end
			end
		end
	endfunction

	function [IW-1:0] pairRows;
		input [PIX_W-1:0] a;
		input [PIX_W-1:0] b;
		input avg;
		reg [IW-1:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			pairRows = avg ? {1'b0, s[IW-1:1]} : s;
		end
	endfunction

	// ****************************************
	// Register file
	// ****************************************
	always @* begin
		widthMax = hx2 ? {1'b0, FULL_W[CNT_W-1:1]} : FULL_W;
		next_rd = 32'h00000000;
		case (wb_adr_i)
			`LRB_OFF_CTRL: next_rd = ctrl;
			`LRB_OFF_WIDTH: next_rd[CNT_W-1:0] = roiWidth;
			`LRB_OFF_OFFX: next_rd[CNT_W-1:0] = roiStart;
			`LRB_OFF_OFFY: next_rd[CNT_W-1:0] = lineMode ? {CNT_W{1'b0}} : roiVertStart;
			`LRB_OFF_WMAX: next_rd[CNT_W-1:0] = widthMax;
			`LRB_OFF_OXMAX: next_rd[CNT_W-1:0] = widthMax - roiWidth;
			`LRB_OFF_STAT: next_rd[15:0] = lineCount;
			default: next_rd = 32'h00000000;
		endcase
		next_wr = merge(next_rd, wb_dat_i, wb_sel_i);
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= `LRB_CTRL_RESET;
			roiWidth <= FULL_W;
			roiStart <= {CNT_W{1'b0}};
			roiVertStart <= {CNT_W{1'b0}};
			prevHx2 <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wbReq;
			prevHx2 <= hx2;
			if (wbReq) begin
				wb_dat_o <= next_rd;
			end
			if (prevHx2 != hx2) begin
				roiWidth <= hx2 ? {1'b0, roiWidth[CNT_W-1:1]} : {roiWidth[CNT_W-2:0], 1'b0};
				roiStart <= hx2 ? {1'b0, roiStart[CNT_W-1:1]} : {roiStart[CNT_W-2:0], 1'b0};
			end else if (wbReq && wb_we_i) begin
				case (wb_adr_i)
					`LRB_OFF_CTRL: ctrl <= next_wr & `LRB_CTRL_MASK;
					`LRB_OFF_WIDTH: roiWidth <= next_wr[CNT_W-1:0];
					`LRB_OFF_OFFX: roiStart <= next_wr[CNT_W-1:0];
					`LRB_OFF_OFFY: begin
						if (!lineMode) begin
							roiVertStart <= next_wr[CNT_W-1:0];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ****************************************
	// Sensor controls
	// ****************************************
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sensorStagesTwo <= 1'b0;
			sensorReadBackward <= 1'b0;
			sensorBinH <= 1'b0;
			sensorBinV <= 1'b0;
			frameFlipped <= 1'b0;
		end else begin
			sensorStagesTwo <= lineMode && ctrl[`LRB_CTRL_STAGES2];
			sensorReadBackward <= backward;
			sensorBinH <= !logicEng && hx2;
			sensorBinV <= !logicEng && vx2;
			frameFlipped <= !lineMode && backward;
		end
	end

	// ****************************************
	// Vertical stage
	// ****************************************
	reg s1Valid;
	reg s1Start;
	reg [IW-1:0] s1Green;
	reg [IW-1:0] s1Other;
	wire [PIX_W-1:0] leadRow;
	wire [PIX_W-1:0] trailRow;

	assign leadRow = backward ? pixBottom : pixTop;
	assign trailRow = backward ? pixTop : pixBottom;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1Valid <= 1'b0;
			s1Start <= 1'b0;
			s1Green <= {IW{1'b0}};
			s1Other <= {IW{1'b0}};
		end else begin
			s1Valid <= pixValid;
			s1Start <= pixLineStart;
			s1Other <= {1'b0, pixBottom};
			if (layout != `LRB_FMT_MONO) begin
				s1Green <= {1'b0, pixTop};
			end else if (logicEng && vx2) begin
				s1Green <= pairRows(leadRow, trailRow, ctrl[`LRB_CTRL_VAVG]);
			end else if (lineMode && ctrl[`LRB_CTRL_STAGES2]) begin
				s1Green <= pairRows(leadRow, trailRow, 1'b0);
			end else begin
				s1Green <= {1'b0, leadRow};
			end
		end
	end

	// ****************************************
	// Horizontal stage
	// ****************************************
	wire hValid;
	wire hStart;
	wire [2*OW-1:0] hData;

	lrb_row_combine #(
		.LANES(2),
		.IW(IW)
	) uCombine (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.factorTwo(logicEng && hx2),
		.average(ctrl[`LRB_CTRL_HAVG]),
		.inValid(s1Valid),
		.inStart(s1Start),
		.inData({s1Other, s1Green}),
		.outValid(hValid),
		.outStart(hStart),
		.outData(hData)
	);

	// ****************************************
	// Region crop and colour layout
	// ****************************************
	reg [CNT_W-1:0] position;
	reg [OW-1:0] prevOther;
	reg firstPend;
	wire [CNT_W-1:0] index;
	wire [OW-1:0] green;
	wire [OW-1:0] other;
	wire inRoi;
	wire redSite;

	assign index = hStart ? {CNT_W{1'b0}} : position;
	assign green = hData[OW-1:0];
	assign other = hData[2*OW-1:OW];
	assign redSite = !index[0];
	assign inRoi = (index >= roiStart) && ({1'b0, index} < {1'b0, roiStart} + {1'b0, roiWidth});

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			position <= {CNT_W{1'b0}};
			prevOther <= {OW{1'b0}};
			firstPend <= 1'b0;
			lineCount <= 16'h0000;
			outValid <= 1'b0;
			outLineStart <= 1'b0;
			outComp0 <= {OW{1'b0}};
			outComp1 <= {OW{1'b0}};
			outComp2 <= {OW{1'b0}};
		end else begin
			outValid <= 1'b0;
			outLineStart <= 1'b0;
			if (hValid) begin
				position <= index + {{(CNT_W-1){1'b0}}, 1'b1};
				prevOther <= other;
				if (hStart) begin
					firstPend <= 1'b1;
				end
				if (inRoi) begin
					outValid <= 1'b1;
					outLineStart <= firstPend || hStart;
					firstPend <= 1'b0;
					if (firstPend || hStart) begin
						lineCount <= lineCount + 16'h0001;
					end
					case (layout)
						`LRB_FMT_MONO: begin
							outComp0 <= green;
							outComp1 <= {OW{1'b0}};
							outComp2 <= {OW{1'b0}};
						end
						`LRB_FMT_RGB: begin
							outComp0 <= redSite ? other : prevOther;
							outComp1 <= green;
							outComp2 <= redSite ? prevOther : other;
						end
						`LRB_FMT_BGR: begin
							outComp0 <= redSite ? prevOther : other;
							outComp1 <= green;
							outComp2 <= redSite ? other : prevOther;
						end
						default: begin
							outComp0 <= other;
							outComp1 <= green;
							outComp2 <= {OW{1'b0}};
						end
					endcase
				end
			end
		end
	end
endmodule // lrb_line_path
`default_nettype wire

// [tb/lrb_line_path_props.sv]
// Checker of bus timing, output framing and sensor control pins.
`timescale 1ns/1ps
`default_nettype none
module lrb_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pixel stream
	input wire logic pixValid,
	input wire logic outValid,
	input wire logic outLineStart,
	// Sensor controls
	input wire logic sensorStagesTwo,
	input wire logic sensorReadBackward,
	input wire logic sensorBinH,
	input wire logic sensorBinV,
	input wire logic frameFlipped
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// ****************
	// Properties
	// ****************
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("Request not answered.");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("Ack longer than one cycle.");
	property p_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_no_ack: assert property (p_no_ack) else $error("Ack without request.");
	property p_dat_hold; $changed(wb_dat_o) |-> wb_ack_o; endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("Read data moved without ack.");
	property p_mode_excl; !(sensorStagesTwo && frameFlipped); endproperty
	a_mode_excl: assert property (p_mode_excl) else $error("Line and area pins both set.");
	property p_start_valid; outLineStart |-> outValid; endproperty
	a_start_valid: assert property (p_start_valid) else $error("Line start without pixel.");
	property p_out_cause; outValid |-> $past(pixValid, 3); endproperty
	a_out_cause: assert property (p_out_cause) else $error("Pixel without input.");
	property p_ctl_cause;
		$changed({sensorStagesTwo, sensorReadBackward, sensorBinH, sensorBinV, frameFlipped})
		|-> (wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2);
	endproperty
	a_ctl_cause: assert property (p_ctl_cause) else $error("Sensor pin moved without write.");
endmodule // lrb_props
bind lrb_line_path lrb_props u_lrb_props (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
	.wb_ack_o, .pixValid, .outValid, .outLineStart, .sensorStagesTwo, .sensorReadBackward, .sensorBinH,
	.sensorBinV, .frameFlipped);
`default_nettype wire

// [tb/lrb_grabber.sv]
// Frame grabber model that captures every output pixel with its line start flag.
`timescale 1ns/1ps
`default_nettype none
module lrb_grabber (
	// Clock
	input wire logic clk_sys,
	// Pixel stream
	input wire logic outValid,
	input wire logic outLineStart,
	input wire logic [13:0] outComp0,
	input wire logic [13:0] outComp1,
	input wire logic [13:0] outComp2
);
	// ****************
	// Capture
	// ****************
	logic [42:0] q[$];
	always @(posedge clk_sys) begin
		if (outValid === 1'b1)
			q.push_back({outLineStart, outComp2, outComp1, outComp0});
	end
endmodule // lrb_grabber
`default_nettype wire

// [tb/test_lrb_line_path.sv]
// Testbench of the line path: register access and pixel scenarios.
`timescale 1ns/1ps
`default_nettype none
`include "lrb_regs.vh"
module test_lrb_line_path;
	// ****************
	// Signals
	// ****************
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic req = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic pixValid = 1'b0;
	logic pixLineStart = 1'b0;
	logic [11:0] pixTop = 12'h0;
	logic [11:0] pixBottom = 12'h0;
	wire logic [31:0] wb_dat_o;
	wire logic wb_ack_o, sensorStagesTwo, sensorReadBackward, sensorBinH, sensorBinV, frameFlipped;
	wire logic outValid, outLineStart;
	wire logic [13:0] outComp0, outComp1, outComp2;
	logic [31:0] rdat;
	int checked = 0;
	int miscompares = 0;
	always #2 clk_sys = ~clk_sys;
	lrb_line_path u_lrb_line_path (.clk_sys, .reset_n, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pixValid, .pixLineStart, .pixTop, .pixBottom,
		.sensorStagesTwo, .sensorReadBackward, .sensorBinH, .sensorBinV, .frameFlipped, .outValid,
		.outLineStart, .outComp0, .outComp1, .outComp2);
	lrb_grabber u_lrb_grabber (.clk_sys, .outValid, .outLineStart, .outComp0, .outComp1, .outComp2);
	// ****************
	// Tasks
	// ****************
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [42:0] s, input logic [42:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_sys);
		req <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 20);
		if (t >= 20) begin
			miscompares++;
			final_report();
		end
		rdat = wb_dat_o;
		req <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(43'(rdat), 43'(e));
	endtask
	function automatic logic [41:0] ex(input int m, input int i);
		int r;
		int b;
		r = (i % 2) ? 99 + i : 100 + i;
		b = (i % 2) ? 100 + i : 99 + i;
		case (m)
			0: ex = 42'(i);
			1: ex = 42'(2 * i + 100);
			2: ex = 42'(4 * i + 1);
			3: ex = 42'(2 * i);
			4: ex = 42'(i + 50);
			5: ex = {14'(b), 14'(i), 14'(r)};
			6: ex = {14'(r), 14'(i), 14'(b)};
			default: ex = {14'h0, 14'(i), 14'(100 + i)};
		endcase
	endfunction
	task automatic run(input int m, input int lo, input int n);
		u_lrb_grabber.q.delete();
		for (int i = 0; i < 40; i++) begin
			pixValid <= 1'b1;
			pixLineStart <= (i == 0);
			pixTop <= 12'(i);
			pixBottom <= 12'(100 + i);
			@(posedge clk_sys);
		end
		pixValid <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk(43'(u_lrb_grabber.q.size()), 43'(n));
		for (int k = 0; k < n; k++) chk(u_lrb_grabber.q[k], {k == 0, ex(m, lo + k)});
	endtask
	// ****************
	// Scenarios
	// ****************
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(`LRB_OFF_CTRL, `LRB_CTRL_RESET);
		rd(`LRB_OFF_WIDTH, 32'h1000);
		rd(`LRB_OFF_WMAX, 32'h1000);
		rd(`LRB_OFF_OXMAX, 32'h0);
		rd(8'h1C, 32'h0);
		wr(`LRB_OFF_OFFY, 32'h5);
		rd(`LRB_OFF_OFFY, 32'h0);
		wr(`LRB_OFF_WIDTH, 32'h18);
		wr(`LRB_OFF_OFFX, 32'h8);
		rd(`LRB_OFF_OXMAX, 32'hFE8);
		run(0, 8, 24);
		wr(`LRB_OFF_CTRL, 32'h3);
		chk(43'(sensorStagesTwo), 43'h1);
		run(1, 8, 24);
		wr(`LRB_OFF_CTRL, 32'h29);
		rd(`LRB_OFF_WIDTH, 32'hC);
		rd(`LRB_OFF_OFFX, 32'h4);
		rd(`LRB_OFF_WMAX, 32'h800);
		run(2, 4, 12);
		wr(`LRB_OFF_CTRL, 32'h39);
		run(3, 4, 12);
		wr(`LRB_OFF_CTRL, 32'hC9);
		rd(`LRB_OFF_WIDTH, 32'h18);
		run(4, 8, 24);
		for (int f = 1; f < 4; f++) begin
			wr(`LRB_OFF_CTRL, 32'h1 | 32'(f << 8));
			run(4 + f, 8, 24);
		end
		rd(`LRB_OFF_STAT, 32'h8);
		wr(`LRB_OFF_CTRL, 32'hA1);
		chk(43'({sensorBinH, sensorBinV}), 43'h3);
		wr(`LRB_OFF_CTRL, 32'h5);
		chk(43'(sensorReadBackward), 43'h1);
		wr(`LRB_OFF_CTRL, 32'h4);
		chk(43'({frameFlipped, sensorStagesTwo}), 43'h2);
		wr(`LRB_OFF_OFFY, 32'h5);
		rd(`LRB_OFF_OFFY, 32'h5);
		final_report();
	end
endmodule // test_lrb_line_path
`default_nettype wire
